// file: shared/cpr_defs.vh
`ifndef CPR_DEFS_VH
`define CPR_DEFS_VH

// ****************************************
// pin synchroniser layout
// ****************************************
`define CPR_PIN_W     22
`define CPR_P_CK      0
`define CPR_P_CS_N    1
`define CPR_P_RAS_N   2
`define CPR_P_CAS_N   3
`define CPR_P_WE_N    4
`define CPR_P_BA_LO   5
`define CPR_P_BA_HI   7
`define CPR_P_A_LO    8
`define CPR_P_A_HI    21
`define CPR_A_W       14

// ****************************************
// mode register select on bank address
// ****************************************
`define CPR_MR0       3'h0
`define CPR_MR1       3'h1
`define CPR_MR2       3'h2
`define CPR_MR_RDO    3'h3

// ****************************************
// mode register field positions
// ****************************************
`define CPR_MR0_BL_LO 0
`define CPR_MR0_BL_HI 1
`define CPR_MR0_CL_LO 4
`define CPR_MR0_CL_HI 6
`define CPR_MR1_AL_LO 3
`define CPR_MR1_AL_HI 4
`define CPR_MR1_WLVL  7
`define CPR_MR2_RTT_LO 9
`define CPR_MR2_RTT_HI 10
`define CPR_RDO_LOC_LO 0
`define CPR_RDO_LOC_HI 1
`define CPR_RDO_EN    2
`define CPR_A_BC_N    12

// ****************************************
// encodings and reset values
// ****************************************
`define CPR_BL_FIX8   2'h0
`define CPR_BL_OTF    2'h1
`define CPR_BL_FIX4   2'h2
`define CPR_AL_CLM1   2'h1
`define CPR_AL_CLM2   2'h2
`define CPR_CL_BASE   5'h04
`define CPR_LOC_PAT   2'h0
`define CPR_PATTERN   8'haa
`define CPR_RST_CL    3'h1

// ****************************************
// read latency pipeline
// ****************************************
`define CPR_SCHED_D   32
`define CPR_BEATS8    4'h7
`define CPR_BEATS4    4'h3
`define CPR_NIB_HI    3'h4

`endif

// file: src/cpr_core.v
// How it works
// - dynamic write termination comes from MR2 A10:A9 without further MRS.
// - write leveling active forces dynamic termination off, nominal only.
// - readout mode register write with A2 high enters readout; A2 low leaves it.
// - in readout mode READ/READA come from the pattern register.
// - active-low reset acts even during readout mode.
// - with A2 low, location bits ignored; accesses go to array.
// - location 00 gives 0,1,0,1...; other locations reserved.
// - by-8: bit on DQ0, copied onto DQ7..DQ1.
// - by-16: both lanes bit 0 carry it, bits 7..1 copy it.
// - eight-beat bursts run in fixed order 0..7.
// - chopped bursts give bits 0..3 for A2=0, 4..7 for A2=1.
// - on-the-fly mode uses A12 to pick chop-4 or eight beats.
// - column A9..A3, A10, A11 and bank bits are ignored.
// - readout reads keep ordinary read latency and output timing.
// - burst bit 0 is the location LSB, bit 7 its MSB.
// - readout register may be read any number of times.
// - burst starts read latency AL plus CL after the command.
`timescale 1ns/10ps
`default_nettype none
`include "cpr_defs.vh"

module cpr_core
(
  // clock, reset, enable
  input  wire        i_mclk,
  input  wire        i_arst_n,
  input  wire        i_ce,
  // command and address pins
  input  wire        i_ck,
  input  wire        i_cs_n,
  input  wire        i_ras_n,
  input  wire        i_cas_n,
  input  wire        i_we_n,
  input  wire [2:0]  i_ba,
  input  wire [13:0] i_addr,
  // data pins, drive side
  output reg  [15:0] o_dq,
  output reg         o_dq_oe,
  output reg         o_dqs,
  output reg         o_dqs_n,
  output reg         o_dqs_oe,
  // mode state and array access strobes toward the rest of the device
  output reg         o_readout_mode,
  output reg  [1:0]  o_rtt_wr,
  output reg         o_dyn_odt_en,
  output reg         o_array_rd,
  output reg         o_array_wr
);

  // ****************************************
  // pin synchroniser
  // ****************************************
  wire [`CPR_PIN_W-1:0] pins_w;
  reg  [`CPR_PIN_W-1:0] s1_reg;
  reg  [`CPR_PIN_W-1:0] s2_reg;
  reg  [`CPR_PIN_W-1:0] s3_reg;
  reg  [`CPR_PIN_W-1:0] pf_reg;
  wire [`CPR_PIN_W-1:0] pf_next;
  reg                   ck_d_reg;

  assign pins_w = {i_addr, i_ba, i_we_n, i_cas_n,
                   i_ras_n, i_cs_n, i_ck};

  // a bit moves only when stages two and three agree
  assign pf_next = (s2_reg & s3_reg) |
                   (pf_reg & (s2_reg ^ s3_reg));

  always @(posedge i_mclk or negedge i_arst_n)
  if (!i_arst_n)
  begin
    s1_reg   <= {`CPR_PIN_W{1'b0}};
    s2_reg   <= {`CPR_PIN_W{1'b0}};
    s3_reg   <= {`CPR_PIN_W{1'b0}};
    pf_reg   <= {`CPR_PIN_W{1'b0}};
    ck_d_reg <= 1'b0;
  end
  else if (i_ce)
  begin
    s1_reg   <= pins_w;
    s2_reg   <= s1_reg;
    s3_reg   <= s2_reg;
    pf_reg   <= pf_next;
    ck_d_reg <= pf_reg[`CPR_P_CK];
  end

  // ****************************************
  // command decode on ck rising edge
  // ****************************************
  wire        ck_rise;
  wire        ck_fall;
  wire        cmd_v;
  wire        is_mrs;
  wire        is_rd;
  wire        is_wr;
  wire [2:0]  ba_w;
  wire [13:0] a_w;

  // pins share the ck delay, so they line up at its edge
  assign ck_rise = pf_reg[`CPR_P_CK] & ~ck_d_reg;
  assign ck_fall = ~pf_reg[`CPR_P_CK] & ck_d_reg;
  assign ba_w    = pf_reg[`CPR_P_BA_HI:`CPR_P_BA_LO];
  assign a_w     = pf_reg[`CPR_P_A_HI:`CPR_P_A_LO];
  assign cmd_v   = ck_rise & ~pf_reg[`CPR_P_CS_N];
  assign is_mrs  = cmd_v & ~pf_reg[`CPR_P_RAS_N] &
                   ~pf_reg[`CPR_P_CAS_N] & ~pf_reg[`CPR_P_WE_N];
  assign is_rd   = cmd_v & pf_reg[`CPR_P_RAS_N] &
                   ~pf_reg[`CPR_P_CAS_N] & pf_reg[`CPR_P_WE_N];
  assign is_wr   = cmd_v & pf_reg[`CPR_P_RAS_N] &
                   ~pf_reg[`CPR_P_CAS_N] & ~pf_reg[`CPR_P_WE_N];

  // ****************************************
  // mode registers, loaded by MRS
  // ****************************************
  reg [1:0] bl_reg;
  reg [2:0] cl_reg;
  reg [1:0] al_reg;
  reg       wlvl_reg;
  reg [1:0] rtt_reg;
  reg       mode_en_reg;
  reg [1:0] loc_reg;

  always @(posedge i_mclk or negedge i_arst_n)
  if (!i_arst_n)
  begin
    bl_reg      <= `CPR_BL_FIX8;
    cl_reg      <= `CPR_RST_CL;
    al_reg      <= 2'h0;
    wlvl_reg    <= 1'b0;
    rtt_reg     <= 2'h0;
    mode_en_reg <= 1'b0;
    loc_reg     <= `CPR_LOC_PAT;
  end
  else if (i_ce && is_mrs)
  begin
    if (ba_w == `CPR_MR0)
    begin
      bl_reg <= a_w[`CPR_MR0_BL_HI:`CPR_MR0_BL_LO];
      cl_reg <= a_w[`CPR_MR0_CL_HI:`CPR_MR0_CL_LO];
    end
    else if (ba_w == `CPR_MR1)
    begin
      al_reg   <= a_w[`CPR_MR1_AL_HI:`CPR_MR1_AL_LO];
      wlvl_reg <= a_w[`CPR_MR1_WLVL];
    end
    else if (ba_w == `CPR_MR2)
      rtt_reg <= a_w[`CPR_MR2_RTT_HI:`CPR_MR2_RTT_LO];
    else if (ba_w == `CPR_MR_RDO)
    begin
      mode_en_reg <= a_w[`CPR_RDO_EN];
      loc_reg     <= a_w[`CPR_RDO_LOC_HI:`CPR_RDO_LOC_LO];
    end
  end

  // ****************************************
  // read latency and burst length
  // ****************************************
  wire [4:0] cl_w;
  reg  [4:0] al_w;
  wire [4:0] rl_w;
  wire       bc4_w;

  assign cl_w = {2'h0, cl_reg} + `CPR_CL_BASE;

  // additive latency picks off CL, reserved code gives zero
  always @*
  begin
    if (al_reg == `CPR_AL_CLM1)
      al_w = cl_w - 5'h01;
    else if (al_reg == `CPR_AL_CLM2)
      al_w = cl_w - 5'h02;
    else
      al_w = 5'h00;
  end

  assign rl_w = cl_w + al_w;

  // A12 only matters with on-the-fly mode set
  assign bc4_w = (bl_reg == `CPR_BL_FIX4) |
                 ((bl_reg == `CPR_BL_OTF) &
                  ~a_w[`CPR_A_BC_N]);

  // ****************************************
  // pending readout reads, one slot per ck
  // ****************************************
  reg  [`CPR_SCHED_D-1:0] sv_reg;
  reg  [`CPR_SCHED_D-1:0] sb_reg;
  reg  [`CPR_SCHED_D-1:0] sa_reg;
  wire [`CPR_SCHED_D-1:0] slot_w;
  wire                    pat_rd;

  // only readout-mode reads are timed here; no limit on how many
  assign pat_rd = is_rd & mode_en_reg;
  assign slot_w = {{(`CPR_SCHED_D-1){1'b0}}, 1'b1}
                  << (rl_w - 5'h01);

  // slot rl-1 drains to slot 0 at the rl-th edge
  always @(posedge i_mclk or negedge i_arst_n)
  if (!i_arst_n)
  begin
    sv_reg <= {`CPR_SCHED_D{1'b0}};
    sb_reg <= {`CPR_SCHED_D{1'b0}};
    sa_reg <= {`CPR_SCHED_D{1'b0}};
  end
  else if (i_ce && ck_rise)
  begin
    sv_reg <= (sv_reg >> 1) |
              (pat_rd ? slot_w : {`CPR_SCHED_D{1'b0}});
    sb_reg <= (sb_reg >> 1) |
              (pat_rd & bc4_w ? slot_w : {`CPR_SCHED_D{1'b0}});
    // A2 is the only column bit used; the rest are ignored
    sa_reg <= (sa_reg >> 1) |
              (pat_rd & bc4_w & a_w[2] ? slot_w
               : {`CPR_SCHED_D{1'b0}});
  end

  // ****************************************
  // burst engine, one beat per ck edge
  // ****************************************
  reg  [3:0] bcnt_reg;
  reg  [2:0] bidx_reg;
  wire [7:0] pat_w;
  wire [2:0] sidx_w;

  // reserved locations read back as zero
  assign pat_w  = (loc_reg == `CPR_LOC_PAT) ?
                  `CPR_PATTERN : 8'h00;
  assign sidx_w = sa_reg[0] ? `CPR_NIB_HI : 3'h0;

  always @(posedge i_mclk or negedge i_arst_n)
  if (!i_arst_n)
  begin
    bcnt_reg <= 4'h0;
    bidx_reg <= 3'h0;
    o_dq     <= 16'h0000;
    o_dq_oe  <= 1'b0;
    o_dqs    <= 1'b0;
    o_dqs_n  <= 1'b1;
    o_dqs_oe <= 1'b0;
  end
  else if (i_ce)
  begin
    if (ck_rise && sv_reg[0])
    begin
      // new burst also cuts in seamlessly after the last
      o_dq     <= {16{pat_w[sidx_w]}};
      bidx_reg <= sidx_w + 3'h1;
      bcnt_reg <= sb_reg[0] ? `CPR_BEATS4 : `CPR_BEATS8;
      o_dq_oe  <= 1'b1;
      o_dqs    <= 1'b1;
      o_dqs_n  <= 1'b0;
      o_dqs_oe <= 1'b1;
    end
    else if ((ck_rise || ck_fall) && bcnt_reg != 4'h0)
    begin
      // strobe high on rising beats, low on falling
      o_dq     <= {16{pat_w[bidx_reg]}};
      bidx_reg <= bidx_reg + 3'h1;
      bcnt_reg <= bcnt_reg - 4'h1;
      o_dqs    <= ck_rise;
      o_dqs_n  <= ~ck_rise;
    end
    else if (ck_rise && sv_reg[1])
    begin
      // preamble: strobe driven low one ck ahead
      o_dq_oe  <= 1'b0;
      o_dqs    <= 1'b0;
      o_dqs_n  <= 1'b1;
      o_dqs_oe <= 1'b1;
    end
    else if (ck_rise)
    begin
      o_dq_oe  <= 1'b0;
      o_dqs    <= 1'b0;
      o_dqs_n  <= 1'b1;
      o_dqs_oe <= 1'b0;
    end
  end

  // ****************************************
  // mode outputs and array access strobes
  // ****************************************
  always @(posedge i_mclk or negedge i_arst_n)
  if (!i_arst_n)
  begin
    o_readout_mode <= 1'b0;
    o_rtt_wr       <= 2'h0;
    o_dyn_odt_en   <= 1'b0;
    o_array_rd     <= 1'b0;
    o_array_wr     <= 1'b0;
  end
  else if (i_ce)
  begin
    o_readout_mode <= mode_en_reg;
    // leveling keeps nominal termination only
    o_rtt_wr       <= wlvl_reg ? 2'h0 : rtt_reg;
    o_dyn_odt_en   <= ~wlvl_reg & (rtt_reg != 2'h0);
    // readout mode off sends every access to the array
    o_array_rd     <= is_rd & ~mode_en_reg;
    o_array_wr     <= is_wr & ~mode_en_reg;
  end

endmodule // cpr_core

`default_nettype wire

// file: test/cpr_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// output checks
// ***
module cpr_checker
(
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  // core outputs
  input wire logic [15:0] o_dq,
  input wire logic        o_dq_oe,
  input wire logic        o_dqs,
  input wire logic        o_dqs_n,
  input wire logic        o_dqs_oe,
  input wire logic        o_readout_mode,
  input wire logic [1:0]  o_rtt_wr,
  input wire logic        o_dyn_odt_en,
  // array access strobe
  input wire logic        o_array_rd
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  // strobe low one ck before the first beat
  sequence s_pre;
    o_dqs_oe && !o_dq_oe && !o_dqs;
  endsequence
  sequence s_beat;
    o_dq_oe && o_dqs;
  endsequence
  strobe_pair_a: assert property (o_dqs_n == !o_dqs)
    else $error("strobe pair not complementary");
  preamble_a: assert property ($rose(o_dqs_oe) |-> s_pre ##[1:16] s_beat)
    else $error("no preamble before burst");
  lane_copy_a: assert property (o_dq_oe |-> o_dq == 16'h0000 || o_dq == 16'hffff)
    else $error("data lanes differ");
  data_strobe_a: assert property (o_dq_oe |-> o_dqs_oe)
    else $error("data without strobe");
  beat_hold_a: assert property ($changed(o_dqs) && o_dq_oe |=> $stable(o_dq)[*4])
    else $error("beat too short");
  odt_level_a: assert property (o_dyn_odt_en |-> o_rtt_wr != 2'h0)
    else $error("termination on with no setting");
  readout_quiet_a: assert property (o_readout_mode && $past(o_readout_mode) |-> !o_array_rd)
    else $error("array read in readout mode");
  // reset must clear state even in readout mode
  reset_clear_a: assert property (disable iff (1'b0) !i_arst_n |-> !o_readout_mode && !o_dqs_oe && !o_dq_oe)
    else $error("reset left readout active");
endmodule // cpr_checker
bind cpr_core cpr_checker u_cpr_checker (.i_mclk, .i_arst_n, .o_dq, .o_dq_oe, .o_dqs, .o_dqs_n,
  .o_dqs_oe, .o_readout_mode, .o_rtt_wr, .o_dyn_odt_en, .o_array_rd);
`default_nettype wire

// file: test/cpr_ctl.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// controller model
// ***
module cpr_ctl #(parameter int MOD_CK = 12, parameter int RECOV_CK = 4)
(
  // link clock and command pins
  output var logic        o_ck,
  output var logic        o_cs_n,
  output var logic        o_ras_n,
  output var logic        o_cas_n,
  output var logic        o_we_n,
  output var logic [2:0]  o_ba,
  output var logic [13:0] o_addr
);
  real t_cmd;
  // ck runs free, offset so it never meets an mclk edge
  initial
  begin
    o_ck = 1'b0;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_ba, o_addr} = '1;
    #1.3;
    forever #24 o_ck = ~o_ck;
  end
  // one command on a ck rise; pins inverted once deselected
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input int gap);
    @(negedge o_ck);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_ba, o_addr} = {c, b, a};
    @(posedge o_ck);
    t_cmd = $realtime;
    @(negedge o_ck);
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n, o_ba, o_addr} = ~{c[2:0], b, a};
    repeat (gap) @(negedge o_ck);
  endtask
  // banks are never opened, so all stay idle
  task automatic mrs(input logic [2:0] b, input logic [13:0] a);
    repeat (RECOV_CK) @(negedge o_ck);
    cmd(4'h0, b, a, MOD_CK);
  endtask
  // column low bits always zero
  task automatic rd(input logic [13:0] a, input int gap);
    cmd(4'h5, 3'h6, {a[13:2], 2'h0}, gap);
  endtask
endmodule // cpr_ctl
`default_nettype wire

// file: test/tb_cpr_core.sv
`timescale 1ns/10ps
`default_nettype none
// ***
// core bench
// ***
module tb_cpr_core;
  logic        i_mclk = 1'b0;
  logic        i_arst_n;
  logic        i_ce = 1'b1;
  wire         i_ck, i_cs_n, i_ras_n, i_cas_n, i_we_n;
  wire  [2:0]  i_ba;
  wire  [13:0] i_addr;
  wire  [15:0] o_dq;
  wire  [1:0]  o_rtt_wr;
  wire         o_dq_oe, o_dqs, o_dqs_n, o_dqs_oe, o_readout_mode, o_dyn_odt_en, o_array_rd, o_array_wr;
  logic [15:0] cap = 16'h0000;
  logic        pdqs = 1'b0;
  int          nb, n_arr, n_mismatch, n_compared;
  real         t_beat;
  real         t_rl = 240.0;

  cpr_core u_cpr_core (.i_mclk, .i_arst_n, .i_ce, .i_ck, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n, .i_ba,
    .i_addr, .o_dq, .o_dq_oe, .o_dqs, .o_dqs_n, .o_dqs_oe, .o_readout_mode, .o_rtt_wr, .o_dyn_odt_en,
    .o_array_rd, .o_array_wr);
  cpr_ctl u_cpr_ctl (.o_ck(i_ck), .o_cs_n(i_cs_n), .o_ras_n(i_ras_n), .o_cas_n(i_cas_n),
    .o_we_n(i_we_n), .o_ba(i_ba), .o_addr(i_addr));

  initial
  begin
    forever #2 i_mclk = ~i_mclk;
  end
  // a beat is taken on every strobe change while data drives
  always @(posedge i_mclk)
  begin
    pdqs <= o_dqs;
    if ((o_array_rd | o_array_wr) === 1'b1) n_arr <= n_arr + 1;
    if (o_dq_oe === 1'b1 && o_dqs !== pdqs)
    begin
      if (nb == 0) t_beat = $realtime;
      cap[nb[3:0]] <= o_dq[0];
      nb <= nb + 1;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // k reads tCCD apart, then the whole train is collected
  task automatic burst(input logic [13:0] a, input int k, input int n, input logic [15:0] exp);
    int w;
    real dt;
    nb = 0;
    cap = 16'h0000;
    repeat (k) u_cpr_ctl.rd(a, 2);
    for (w = 0; w < 400 && o_dq_oe !== 1'b1; w++) @(posedge i_mclk);
    for (w = 0; w < 400 && o_dq_oe !== 1'b0; w++) @(posedge i_mclk);
    chk(16'(nb), 16'(n));
    chk(cap, exp);
    dt = t_beat - u_cpr_ctl.t_cmd;
    if (k == 1) chk({15'h0, dt > t_rl && dt < t_rl + 40.0}, 16'h1);
  endtask
  // array command; counts pulses it raised
  task automatic arr(input logic [3:0] c, input int exp);
    int n0;
    n0 = n_arr;
    u_cpr_ctl.cmd(c, 3'h0, 14'h0400, 8);
    chk(16'(n_arr - n0), 16'(exp));
  endtask

  initial
  begin
    // x to 0 gives the async reset a real falling edge at start
    i_arst_n <= 1'b0;
    repeat (6) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (40) @(posedge i_mclk); // wait for lock before any read
    arr(4'h5, 1);
    arr(4'h4, 1);
    u_cpr_ctl.mrs(3'h2, 14'h0400);
    chk({13'h0, o_rtt_wr, o_dyn_odt_en}, 16'h5);
    u_cpr_ctl.mrs(3'h1, 14'h0080);
    chk({13'h0, o_rtt_wr, o_dyn_odt_en}, 16'h0);
    u_cpr_ctl.mrs(3'h1, 14'h0000);
    $display("test termination done");
    // on-the-fly chop, CL code 1, then readout on
    u_cpr_ctl.mrs(3'h0, 14'h0011);
    u_cpr_ctl.mrs(3'h3, 14'h0004);
    chk({15'h0, o_readout_mode}, 16'h1);
    // only reads and MR3 writes from here until readout is off
    burst(14'h1ff8, 1, 8, 16'h00aa);
    burst(14'h0000, 1, 4, 16'h000a);
    burst(14'h0004, 1, 4, 16'h000a);
    burst(14'h1000, 2, 16, 16'haaaa);
    arr(4'h5, 0);
    u_cpr_ctl.mrs(3'h3, 14'h0005);
    burst(14'h1000, 1, 8, 16'h0000);
    u_cpr_ctl.mrs(3'h3, 14'h0003);
    chk({15'h0, o_readout_mode}, 16'h0);
    arr(4'h5, 1);
    $display("test readout done");
    u_cpr_ctl.mrs(3'h3, 14'h0004);
    chk({15'h0, o_readout_mode}, 16'h1);
    @(posedge i_mclk);
    i_arst_n <= 1'b0;
    repeat (6) @(posedge i_mclk);
    chk({15'h0, o_readout_mode}, 16'h0);
    i_arst_n <= 1'b1;
    repeat (40) @(posedge i_mclk);
    arr(4'h5, 1);
    $display("test reset done");
    // additive latency CL-1 gives RL of 9 ck
    u_cpr_ctl.mrs(3'h1, 14'h0008);
    u_cpr_ctl.mrs(3'h3, 14'h0004);
    t_rl = 432.0;
    burst(14'h1000, 1, 8, 16'h00aa);
    $display("test latency done");
    end_sim;
  end
  // whole run needs about 15 us
  initial
  begin
    #200000;
    n_mismatch++;
    end_sim;
  end
endmodule // tb_cpr_core
`default_nettype wire
